// [logic/tdt_tx_desc_ctrl.sv]
// Transmit descriptor prefetch, write-back and absolute delay control.
// Assumes an APB master and queue logic on REF_CLK driving the event inputs.
`timescale 1ns/1ps
module tdt_tx_desc_ctrl (
  input  logic        REF_CLK,
  input  logic        RST_N,
  input  logic        PSEL,
  input  logic        PENABLE,
  input  logic        PWRITE,
  input  logic [15:0] PADDR,
  input  logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic        PREADY,
  output logic        PSLVERR,
  input  logic [7:0]  ONCHIP_COUNT,
  input  logic [15:0] HOST_AVAIL,
  input  logic        DMA_BUSY,
  input  logic [15:0] PENDING_COUNT,
  input  logic        DESC_DONE,
  input  logic        DONE_RS,
  input  logic        DONE_IDE,
  input  logic        DONE_TX_OK,
  input  logic        FLUSH_REQ,
  input  logic        REL_EXPIRE,
  output logic        PREFETCH_REQ,
  output logic        WB_VALID,
  input  logic        WB_READY,
  output logic [7:0]  WB_COUNT,
  output logic        DESCRIPTOR_WRITTEN_BACK_CAUSE_CAUSE,
  output logic        DESC_LOW_CAUSE
);

  // Threshold field to descriptor count
  function automatic logic [8:0] to_desc(input logic [5:0] v, input logic unit);
    logic [8:0] r;
    r = unit ? {3'h0, v} : 9'({3'h0, v} * tdt_pkg::DESC_PER_LINE);
    return r;
  endfunction : to_desc

  logic [31:0] ctrl_q;
  logic [31:0] abs_q;
  logic        pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic        pf_q;
  logic [7:0]  wb_cnt_q;
  logic [7:0]  wb_cnt_d;
  logic        acc_q;
  logic        acc_d;
  logic        flush_pend_q;
  logic        flush_pend_d;
  logic        descriptor_written_back_cause_q;
  logic        low_q;
  logic [15:0] pend_prev_q;
  logic        abs_run_q;
  logic        abs_run_d;
  logic [15:0] abs_cnt_q;
  logic [6:0]  pre_q;
  logic        buf_in_ready;

  // APB decode
  wire         setup     = PSEL & ~PENABLE;
  wire         access    = PSEL & PENABLE & pready_q;
  wire         hit_ctrl  = PADDR == tdt_pkg::CTRL_OFFSET;
  wire         hit_abs   = PADDR == tdt_pkg::ABS_OFFSET;
  wire         hit_stat  = PADDR == tdt_pkg::STATUS_OFFSET;
  wire         hit_any   = hit_ctrl | hit_abs | hit_stat;
  wire         wr_ctrl   = access & PWRITE & hit_ctrl;
  wire         wr_abs    = access & PWRITE & hit_abs;
  wire [31:0]  stat_word = {6'h00, abs_cnt_q, abs_run_q, acc_q, wb_cnt_q};
  wire [31:0]  rd_mux    = hit_ctrl ? ctrl_q : (hit_abs ? abs_q :
                           (hit_stat ? stat_word : 32'h00000000));

  // Control fields
  wire [5:0]   pf_f   = ctrl_q[tdt_pkg::PF_LSB +: tdt_pkg::THR_W];
  wire [5:0]   host_f = ctrl_q[tdt_pkg::HOST_LSB +: tdt_pkg::THR_W];
  wire [5:0]   wb_f   = ctrl_q[tdt_pkg::WB_LSB +: tdt_pkg::THR_W];
  wire         unit_f = ctrl_q[tdt_pkg::UNIT_BIT];
  wire [6:0]   low_f  = ctrl_q[tdt_pkg::LOW_LSB +: tdt_pkg::LOW_W];
  wire [15:0]  abs_f  = abs_q[tdt_pkg::ABS_LSB +: tdt_pkg::ABS_W];

  // Thresholds in descriptors
  wire [8:0]   pf_thr   = to_desc(pf_f, unit_f);
  wire [8:0]   host_thr = to_desc(host_f, unit_f);
  wire [8:0]   wb_thr   = to_desc(wb_f, unit_f);
  wire [15:0]  low_thr  = low_f == 7'h00 ? 16'h0001 :
                          16'({9'h000, low_f} * tdt_pkg::LOW_UNIT);

  // Prefetch decision
  wire         pf_below = {1'b0, ONCHIP_COUNT} < pf_thr;
  wire         pf_host  = HOST_AVAIL >= {7'h00, host_thr};
  wire         pf_cond  = pf_below & pf_host & ~DMA_BUSY;

  // Write-back accumulation
  wire         counted  = DESC_DONE & (acc_q | DONE_RS);
  wire [7:0]   cnt_inc  = counted && wb_cnt_q != 8'hff ? wb_cnt_q + 8'h01 : wb_cnt_q;
  wire         has_cnt  = cnt_inc != 8'h00;
  wire         wb_imm   = wb_thr == 9'h000 && has_cnt;
  wire         wb_over  = {1'b0, cnt_inc} > wb_thr;
  wire         wb_ext   = (flush_pend_q | FLUSH_REQ | REL_EXPIRE) & has_cnt;
  wire         wb_want  = wb_imm | wb_over | wb_ext;
  wire         wb_push  = wb_want & buf_in_ready;

  assign wb_cnt_d     = wb_push ? 8'h00 : cnt_inc;
  assign acc_d        = wb_push ? 1'b0 : (acc_q | (DESC_DONE & DONE_RS));
  assign flush_pend_d = (flush_pend_q | FLUSH_REQ | REL_EXPIRE) & ~wb_push & has_cnt;

  // Absolute delay timer
  wire         immediate = DESC_DONE & DONE_RS & ~DONE_IDE;
  wire         abs_qual  = DESC_DONE & DONE_RS & DONE_IDE;
  wire         abs_start = abs_qual & DONE_TX_OK & (abs_f != 16'h0000) & ~abs_run_q;
  wire         abs_tick  = abs_run_q & (pre_q == tdt_pkg::STEP_CYCLES - 7'h01);
  wire         abs_exp   = abs_tick & (abs_cnt_q == 16'h0001);
  wire         abs_stop  = immediate | REL_EXPIRE | (abs_f == 16'h0000);

  assign abs_run_d = abs_start ? 1'b1 : ((abs_exp | abs_stop) ? 1'b0 : abs_run_q);

  // Descriptor-low edge
  wire         low_fire = pend_prev_q >= low_thr && PENDING_COUNT < low_thr;

  // Register file
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      ctrl_q <= tdt_pkg::CTRL_RESET;
      abs_q  <= tdt_pkg::ABS_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= PWDATA & tdt_pkg::CTRL_WMASK;
      end
      if (wr_abs) begin
        abs_q <= PWDATA & tdt_pkg::ABS_WMASK;
      end
    end
  end

  // APB answer, one wait-free access phase
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup;
      prdata_q  <= setup ? rd_mux : prdata_q;
      pslverr_q <= setup & ~hit_any;
    end
  end

  // Queue state
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      pf_q         <= 1'b0;
      wb_cnt_q     <= 8'h00;
      acc_q        <= 1'b0;
      flush_pend_q <= 1'b0;
      descriptor_written_back_cause_q       <= 1'b0;
      low_q        <= 1'b0;
      pend_prev_q  <= 16'h0000;
    end else begin
      pf_q         <= pf_cond;
      wb_cnt_q     <= wb_cnt_d;
      acc_q        <= acc_d;
      flush_pend_q <= flush_pend_d;
      descriptor_written_back_cause_q       <= abs_exp | immediate | REL_EXPIRE;
      low_q        <= low_fire;
      pend_prev_q  <= PENDING_COUNT;
    end
  end

  // Absolute countdown
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      abs_run_q <= 1'b0;
      abs_cnt_q <= 16'h0000;
      pre_q     <= 7'h00;
    end else begin
      abs_run_q <= abs_run_d;
      if (abs_start) begin
        abs_cnt_q <= abs_f;
        pre_q     <= 7'h00;
      end else if (abs_run_q) begin
        abs_cnt_q <= abs_tick ? abs_cnt_q - 16'h0001 : abs_cnt_q;
        pre_q     <= abs_tick ? 7'h00 : pre_q + 7'h01;
      end
    end
  end

  tdt_pair_buffer #(
    .W (8)
  ) u_wb_buf (
    .clk       (REF_CLK),
    .rst_n     (RST_N),
    .in_valid  (wb_push),
    .in_ready  (buf_in_ready),
    .in_data   (cnt_inc),
    .out_valid (WB_VALID),
    .out_ready (WB_READY),
    .out_data  (WB_COUNT)
  );

  assign PREADY         = pready_q;
  assign PRDATA         = prdata_q;
  assign PSLVERR        = pslverr_q;
  assign PREFETCH_REQ   = pf_q;
  assign DESCRIPTOR_WRITTEN_BACK_CAUSE_CAUSE     = descriptor_written_back_cause_q;
  assign DESC_LOW_CAUSE = low_q;

  // Checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  a_prefetch_below: assert property (
    PREFETCH_REQ |-> $past(pf_below))
    else $error("prefetch raised without low on-chip count");

  a_prefetch_host: assert property (
    PREFETCH_REQ |-> $past(HOST_AVAIL) >= $past({7'h00, host_thr}))
    else $error("prefetch raised with too few host descriptors");

  a_prefetch_busy: assert property (
    DMA_BUSY |=> !PREFETCH_REQ)
    else $error("prefetch raised during busy DMA");

  a_wb_exceeds: assert property (
    WB_VALID && $rose(WB_VALID) && !$past(flush_pend_q | FLUSH_REQ | REL_EXPIRE)
      |-> {1'b0, WB_COUNT} > $past(wb_thr) || $past(wb_thr) == 9'h000)
    else $error("write-back below threshold");

  a_wb_each: assert property (
    wb_thr == 9'h000 && counted && buf_in_ready |=> WB_VALID)
    else $error("zero threshold did not write back at once");

  a_unit_desc: assert property (
    unit_f |-> pf_thr == {3'h0, pf_f} && wb_thr == {3'h0, wb_f})
    else $error("descriptor units not taken as is");

  a_unit_line: assert property (
    !unit_f |-> wb_thr == 9'({3'h0, wb_f} * tdt_pkg::DESC_PER_LINE))
    else $error("cache line units not converted");

  a_low_drop: assert property (
    DESC_LOW_CAUSE |-> $past(PENDING_COUNT) < $past(low_thr) &&
      $past(pend_prev_q) >= $past(low_thr))
    else $error("low cause without downward crossing");

  a_low_empty: assert property (
    DESC_LOW_CAUSE && $past(low_f) == 7'h00 |-> $past(PENDING_COUNT) == 16'h0000)
    else $error("zero low level fired while not empty");

  a_ctrl_reserved: assert property (
    access && !PWRITE && hit_ctrl |-> (PRDATA & ~tdt_pkg::CTRL_WMASK) == 32'h00000000)
    else $error("control reserved bits not zero");

  a_abs_reserved: assert property (
    access && !PWRITE && hit_abs |-> PRDATA[31:16] == 16'h0000)
    else $error("delay reserved bits not zero");

  a_abs_disabled: assert property (
    abs_f == 16'h0000 |=> !abs_run_q)
    else $error("absolute timer runs while disabled");

  a_abs_qualify: assert property (
    $rose(abs_run_q) |-> $past(DESC_DONE & DONE_RS & DONE_IDE & DONE_TX_OK))
    else $error("timer started by unqualified descriptor");

  a_abs_load: assert property (
    abs_start |=> abs_run_q && abs_cnt_q == $past(abs_f))
    else $error("countdown not loaded");

  a_abs_expiry: assert property (
    abs_exp |=> DESCRIPTOR_WRITTEN_BACK_CAUSE_CAUSE && !abs_run_q)
    else $error("expiry did not set cause");

  a_abs_halt: assert property (
    abs_run_q && (immediate || REL_EXPIRE) && !abs_start |=>
      !abs_run_q ##1 (!abs_run_q || $past(abs_start)))
    else $error("countdown not halted");

  a_imm_cause: assert property (
    immediate |=> DESCRIPTOR_WRITTEN_BACK_CAUSE_CAUSE)
    else $error("no immediate cause");

  a_acc_gate: assert property (
    !acc_q && DESC_DONE && !DONE_RS |=> wb_cnt_q == 8'h00)
    else $error("counted before report-status");

  a_rel_flush: assert property (
    REL_EXPIRE && has_cnt && buf_in_ready |=> WB_VALID && DESCRIPTOR_WRITTEN_BACK_CAUSE_CAUSE)
    else $error("relative expiry did not flush");

  a_prefetch_issue: assert property (
    pf_cond |=> PREFETCH_REQ)
    else $error("prefetch condition held but no request");

  a_wb_hold: assert property (
    WB_VALID && !WB_READY |=> WB_VALID && $stable(WB_COUNT))
    else $error("write-back word dropped while stalled");

  a_flush_kept: assert property (
    (FLUSH_REQ || REL_EXPIRE) && has_cnt && !buf_in_ready |=> flush_pend_q)
    else $error("flush lost while buffer full");

  a_abs_step: assert property (
    abs_run_q && !abs_tick && !abs_stop |=> abs_run_q && pre_q == $past(pre_q) + 7'h01)
    else $error("step prescaler did not advance");

  a_abs_count: assert property (
    abs_tick && !abs_exp && !abs_stop |=>
      abs_run_q && abs_cnt_q == $past(abs_cnt_q) - 16'h0001)
    else $error("countdown did not decrement");

  a_rel_stop: assert property (
    REL_EXPIRE && !abs_start |=> !abs_run_q)
    else $error("relative expiry left countdown running");

  a_ctrl_write: assert property (
    wr_ctrl |=> ctrl_q == ($past(PWDATA) & tdt_pkg::CTRL_WMASK))
    else $error("control write not masked");

  a_abs_write: assert property (
    wr_abs |=> abs_q == ($past(PWDATA) & tdt_pkg::ABS_WMASK))
    else $error("delay write not masked");

  c_prefetch: cover property (pf_cond ##1 PREFETCH_REQ);
  c_abs_expire: cover property (abs_start ##[1:1000] abs_exp);
  c_wb_stall: cover property (wb_want && !buf_in_ready ##[1:20] wb_push);
  c_low_cause: cover property (DESC_LOW_CAUSE);
  c_abs_halt: cover property (abs_run_q && REL_EXPIRE ##1 !abs_run_q);
endmodule : tdt_tx_desc_ctrl

// [logic/tdt_pkg.sv]
// Constants shared by the transmit descriptor threshold and timer block.
// Assumes a 100 MHz core clock and 32-bit APB register access.
package tdt_pkg;
  // Register byte offsets
  localparam logic [15:0] CTRL_OFFSET   = 16'h3828;
  localparam logic [15:0] ABS_OFFSET    = 16'h382c;
  localparam logic [15:0] STATUS_OFFSET = 16'h3830;
  // Control and delay register fields
  localparam int PF_LSB    = 0;
  localparam int HOST_LSB  = 8;
  localparam int WB_LSB    = 16;
  localparam int UNIT_BIT  = 24;
  localparam int LOW_LSB   = 25;
  localparam int THR_W     = 6;
  localparam int LOW_W     = 7;
  localparam int ABS_LSB   = 0;
  localparam int ABS_W     = 16;
  // Writable bits and reset values
  localparam logic [31:0] CTRL_WMASK = 32'hff3f3f3f;
  localparam logic [31:0] ABS_WMASK  = 32'h0000ffff;
  localparam logic [31:0] CTRL_RESET = 32'h00000000;
  localparam logic [31:0] ABS_RESET  = 32'h00000000;
  // Threshold units
  localparam int DESC_BYTES       = 16;
  localparam int CACHE_LINE_BYTES = 64;
  localparam int DESC_PER_LINE    = CACHE_LINE_BYTES / DESC_BYTES;
  localparam int LOW_UNIT         = 8;
  // Absolute delay step of 1.024 us
  localparam int STEP_NS          = 1024;
  localparam int CLK_PERIOD_NS    = 10;
  localparam logic [6:0] STEP_CYCLES = 7'(STEP_NS / CLK_PERIOD_NS);
endpackage : tdt_pkg

// [logic/tdt_pair_buffer.sv]
// Two-entry buffer for write-back requests, valid and ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module tdt_pair_buffer #(
  parameter int W = 8
) (
  input  logic         clk,
  input  logic         rst_n,
  input  logic         in_valid,
  output logic         in_ready,
  input  logic [W-1:0] in_data,
  output logic         out_valid,
  input  logic         out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] head_q;
  logic [W-1:0] tail_q;
  logic [1:0]   cnt_q;
  logic [1:0]   cnt_d;
  logic         vld_q;
  logic         full_q;
  wire          push = in_valid & ~full_q;
  wire          pop  = vld_q & out_ready;

  assign cnt_d     = push & ~pop ? cnt_q + 2'h1 : (pop & ~push ? cnt_q - 2'h1 : cnt_q);
  assign in_ready  = ~full_q;
  assign out_valid = vld_q;
  assign out_data  = head_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q  <= 2'h0;
      vld_q  <= 1'b0;
      full_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      vld_q  <= cnt_d != 2'h0;
      full_q <= cnt_d == 2'h2;
    end
  end

  // Head shifts from tail on a pop; new words land in the first free slot
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      head_q <= '0;
      tail_q <= '0;
    end else if (push & (cnt_q == 2'h0 || (pop && cnt_q == 2'h1))) begin
      head_q <= in_data;
    end else if (pop) begin
      head_q <= tail_q;
      if (push) begin
        tail_q <= in_data;
      end
    end else if (push) begin
      tail_q <= in_data;
    end
  end
endmodule : tdt_pair_buffer

// [verification/tdt_host_model.sv]
// Host memory side model: takes write-back bursts and tallies descriptors.
// Assumes the bench drives stall on the same clock as the block.
`timescale 1ns/1ps
module tdt_host_model (
  input  logic       clk,
  input  logic       rst_n,
  input  logic       stall,
  input  logic       wb_valid,
  output logic       wb_ready,
  input  logic [7:0] wb_count,
  output int         wb_total
);
  // Ready follows the stall request one cycle late, like a busy memory port
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wb_ready <= 1'b0;
      wb_total <= 0;
    end else begin
      wb_ready <= !stall;
      if (wb_valid && wb_ready) begin
        wb_total <= wb_total + int'(wb_count);
      end
    end
  end
endmodule : tdt_host_model

// [verification/test_tx_descriptor_threshold_timer.sv]
// Bench for the descriptor threshold block: registers, prefetch, write-back, timer.
// Assumes tdt_host_model on the write-back side and the tdt_pkg constants.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin err_total++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module test_tx_descriptor_threshold_timer;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h00000000;
  logic [7:0]  onchip = 8'h00;
  logic [15:0] host_avail = 16'h0000;
  logic [15:0] pending = 16'h0000;
  logic        dma_busy = 1'b0;
  logic        done = 1'b0;
  logic        done_rs = 1'b0;
  logic        done_ide = 1'b0;
  logic        done_ok = 1'b0;
  logic        flush = 1'b0;
  logic        rel_exp = 1'b0;
  logic        stall = 1'b0;
  logic [31:0] seed = 32'h90c687f7;
  logic [31:0] prdata, rd, c, r;
  logic [7:0]  wb_count, oc;
  logic [15:0] ha;
  logic        pready, pslverr, er, prefetch, wb_valid, wb_ready, descriptor_written_back_cause, desc_low, hit;
  logic [15:0] lv [8] = '{16'h10, 16'h09, 16'h08, 16'h07, 16'h00, 16'h05, 16'h01, 16'h00};
  logic [7:0]  le = 8'h88;
  int          err_total = 0;
  int          cmp_count = 0;
  int          wb_total, n, m, t0;

  tdt_tx_desc_ctrl i_dut (
    .REF_CLK(ref_clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .ONCHIP_COUNT(onchip), .HOST_AVAIL(host_avail), .DMA_BUSY(dma_busy),
    .PENDING_COUNT(pending), .DESC_DONE(done), .DONE_RS(done_rs), .DONE_IDE(done_ide),
    .DONE_TX_OK(done_ok), .FLUSH_REQ(flush), .REL_EXPIRE(rel_exp),
    .PREFETCH_REQ(prefetch), .WB_VALID(wb_valid), .WB_READY(wb_ready),
    .WB_COUNT(wb_count), .DESCRIPTOR_WRITTEN_BACK_CAUSE_CAUSE(descriptor_written_back_cause), .DESC_LOW_CAUSE(desc_low));

  tdt_host_model i_host (
    .clk(ref_clk), .rst_n(rst_n), .stall(stall), .wb_valid(wb_valid),
    .wb_ready(wb_ready), .wb_count(wb_count), .wb_total(wb_total));

  always #5 ref_clk = ~ref_clk;

  // Expected prefetch request from the prefetch and host thresholds, the unit select and DMA busy
  function automatic logic pf_expect(logic [31:0] cv, logic [7:0] o, logic [15:0] h,
                                     logic b);
    int k;
    k = cv[24] ? 1 : tdt_pkg::DESC_PER_LINE;
    return (int'(o) < int'(cv[5:0]) * k) && (int'(h) >= int'(cv[13:8]) * k) && !b;
  endfunction : pf_expect

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict

  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb

  task automatic pulse_done(input logic rs, input logic delay_enable_flag);
    @(posedge ref_clk);
    {done, done_rs, done_ide, done_ok} <= {1'b1, rs, delay_enable_flag, 1'b1};
    @(posedge ref_clk);
    {done, done_rs, done_ide, done_ok} <= 4'h0;
  endtask : pulse_done

  task automatic strobe(input logic f, input logic x);
    @(posedge ref_clk);
    {flush, rel_exp} <= {f, x};
    @(posedge ref_clk);
    {flush, rel_exp} <= 2'b00;
  endtask : strobe

  // Counts edges until the written-back cause shows, up to lim
  task automatic wait_descriptor_written_back_cause(input int lim);
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (descriptor_written_back_cause !== 1'b1 && n < lim);
  endtask : wait_descriptor_written_back_cause

  task automatic low_seen(input logic [15:0] v);
    @(posedge ref_clk);
    pending <= v;
    hit = 1'b0;
    repeat (3) begin
      @(posedge ref_clk);
      #1;
      hit = hit | desc_low;
    end
  endtask : low_seen

  initial begin
    repeat (60000) @(posedge ref_clk);
    err_total++;
    print_verdict();
  end

  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    apb(1'b0, tdt_pkg::CTRL_OFFSET, 32'h00000000);
    `CHK("ctrl reset", 32'h00000000, rd)
    apb(1'b0, tdt_pkg::ABS_OFFSET, 32'h00000000);
    `CHK("abs reset", 32'h00000000, rd)
    apb(1'b1, tdt_pkg::CTRL_OFFSET, 32'hffffffff);
    apb(1'b0, tdt_pkg::CTRL_OFFSET, 32'h00000000);
    `CHK("ctrl readback", ~32'h00c0c0c0, rd)
    apb(1'b1, tdt_pkg::ABS_OFFSET, 32'hffffffff);
    apb(1'b0, tdt_pkg::ABS_OFFSET, 32'h00000000);
    `CHK("abs readback", 32'h0000ffff, rd)
    `CHK("abs slverr", 1'b0, er)
    apb(1'b0, 16'h3834, 32'h00000000);
    `CHK("unmapped slverr", 1'b1, er)
    apb(1'b1, tdt_pkg::ABS_OFFSET, 32'h00000000);
    // Low cause: level 1 means eight descriptors, then level 0 means empty
    apb(1'b1, tdt_pkg::CTRL_OFFSET, 32'h02000000);
    for (int i = 0; i < 8; i++) begin
      if (i == 5) apb(1'b1, tdt_pkg::CTRL_OFFSET, 32'h00000000);
      low_seen(lv[i]);
      `CHK("low cause", le[i], hit)
    end
    // Random thresholds with boundary values mixed in
    for (int i = 0; i < 40; i++) begin
      c = $random(seed);
      apb(1'b1, tdt_pkg::CTRL_OFFSET, c);
      m = c[24] ? 1 : tdt_pkg::DESC_PER_LINE;
      repeat (4) begin
        r = $random(seed);
        oc = r[0] ? 8'(int'(c[5:0]) * m) : r[15:8];
        ha = r[1] ? 16'(int'(c[13:8]) * m) : {8'h00, r[23:16]};
        @(posedge ref_clk);
        {onchip, host_avail, dma_busy} <= {oc, ha, r[31:29] == 3'b000};
        @(posedge ref_clk);
        #1;
        `CHK("prefetch", pf_expect(c, oc, ha, r[31:29] == 3'b000), prefetch)
      end
    end
    apb(1'b1, tdt_pkg::CTRL_OFFSET, 32'h01000000);
    pulse_done(1'b1, 1'b0);
    #1;
    `CHK("single burst", 9'h101, {wb_valid, wb_count})
    apb(1'b1, tdt_pkg::CTRL_OFFSET, 32'h01020000);
    stall <= 1'b1;
    t0 = wb_total;
    for (int k = 0; k < 3; k++) begin
      pulse_done(1'b0, 1'b0);
      pulse_done(1'b1, 1'b0);
      pulse_done(1'b0, 1'b0);
      repeat (3) @(posedge ref_clk);
      if (k == 0) `CHK("early burst", 1'b0, wb_valid)
      pulse_done(1'b0, 1'b0);
      #1;
      if (k == 0) `CHK("burst", 9'h103, {wb_valid, wb_count})
    end
    `CHK("stalled total", t0, wb_total)
    stall <= 1'b0;
    repeat (20) @(posedge ref_clk);
    #1;
    `CHK("drained total", t0 + 9, wb_total)
    `CHK("drained", 1'b0, wb_valid)
    pulse_done(1'b1, 1'b0);
    pulse_done(1'b0, 1'b0);
    strobe(1'b1, 1'b0);
    repeat (5) @(posedge ref_clk);
    `CHK("flush total", t0 + 11, wb_total)
    pulse_done(1'b1, 1'b0);
    strobe(1'b0, 1'b1);
    repeat (5) @(posedge ref_clk);
    `CHK("relative flush", t0 + 12, wb_total)
    // Absolute timer
    wait_descriptor_written_back_cause(150);
    apb(1'b1, tdt_pkg::ABS_OFFSET, 32'h00000001);
    pulse_done(1'b1, 1'b1);
    wait_descriptor_written_back_cause(200);
    `CHK("expiry", 1'b1, n >= tdt_pkg::STEP_CYCLES - 2 && n <= tdt_pkg::STEP_CYCLES + 3)
    pulse_done(1'b1, 1'b1);
    repeat (10) @(posedge ref_clk);
    strobe(1'b0, 1'b1);
    #1;
    `CHK("relative cause", 1'b1, descriptor_written_back_cause)
    wait_descriptor_written_back_cause(150);
    `CHK("halted by relative", 1'b0, descriptor_written_back_cause)
    pulse_done(1'b1, 1'b1);
    repeat (10) @(posedge ref_clk);
    pulse_done(1'b1, 1'b0);
    #1;
    `CHK("immediate cause", 1'b1, descriptor_written_back_cause)
    wait_descriptor_written_back_cause(150);
    `CHK("halted by immediate", 1'b0, descriptor_written_back_cause)
    pulse_done(1'b0, 1'b1);
    wait_descriptor_written_back_cause(150);
    `CHK("no status flag", 1'b0, descriptor_written_back_cause)
    apb(1'b1, tdt_pkg::ABS_OFFSET, 32'h00000000);
    pulse_done(1'b1, 1'b1);
    wait_descriptor_written_back_cause(150);
    `CHK("disabled timer", 1'b0, descriptor_written_back_cause)
    print_verdict();
  end
endmodule : test_tx_descriptor_threshold_timer
